// ---- rtl/tooth_edge_switching_core.sv ----
// Module: digital switching core of a Hall speed sensor, power-on, start-up, running
`timescale 1ns/1ps

module tooth_edge_switching_core
  import tooth_edge_pkg::*;
#(
  parameter int unsigned            POWER_ON_CNT    = POWER_ON_CYCLES,
  parameter logic [SAMPLE_W-1:0]    MIN_SIGNAL_STEP = SAMPLE_W'(MIN_SIGNAL_STEP_DEF)
)
(
  input  wire logic    clk_sys_in,
  input  wire logic    rst_in,
  input  wire sample_t sample_in,
  output logic         speed_out,
  output logic         running_out
);

  // ==========================================================================
  // State
  // ==========================================================================
  core_state_t st_reg;
  core_state_t st_next;

  level_t thr;
  level_t pos_lvl;
  level_t neg_lvl;
  level_t smp;
  level_t rise_diff;
  level_t fall_diff;
  level_t step;
  logic   rise_seen;
  logic   fall_seen;
  logic   por_done;

  // Sign extension of a field value to the level width, used by both step detectors
  function automatic level_t widen(input field_t f);
    return level_t'({f[SAMPLE_W-1], f});
  endfunction : widen

  // ==========================================================================
  // Threshold and hysteresis levels
  // ==========================================================================
  // Levels come from the latched extremes, so they move only at a detected
  // edge (a first start-up fall shows no output edge) and never chase the sample that is being compared against them.
  switch_level_calc u_level (
    .min_in  (st_reg.min_val),
    .max_in  (st_reg.max_val),
    .thr_out (thr),
    .pos_out (pos_lvl),
    .neg_out (neg_lvl)
  );

  // ==========================================================================
  // Sample step detection
  // ==========================================================================
  always_comb begin
    smp       = level_t'(sample_in.field);
    step      = level_t'({1'b0, MIN_SIGNAL_STEP});
    // One bit wider so a full-scale swing cannot wrap to a negative step
    rise_diff = widen(sample_in.field) - widen(st_reg.cur_min);
    fall_diff = widen(st_reg.cur_max) - widen(sample_in.field);
    rise_seen = rise_diff > step;
    fall_seen = fall_diff > step;
    por_done  = st_reg.por_cnt >= POR_CNT_W'(POWER_ON_CNT - 1);
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    st_next = st_reg;

    case (st_reg.mode)

      // ----------------------------------------------------------------------
      MODE_POWER_ON: begin
        // Analog working points settle; samples are not trusted here
        st_next.speed = 1'b1;
        if (!por_done) begin
          st_next.por_cnt = st_reg.por_cnt + POR_CNT_W'(1);
        end else if (sample_in.valid) begin
          st_next.mode    = MODE_STARTUP;
          st_next.cur_min = sample_in.field;
          st_next.cur_max = sample_in.field;
        end
      end

      // ----------------------------------------------------------------------
      MODE_STARTUP: begin
        if (sample_in.valid) begin
          if (sample_in.field < st_reg.cur_min) begin
            st_next.cur_min = sample_in.field;
          end
          if (sample_in.field > st_reg.cur_max) begin
            st_next.cur_max = sample_in.field;
          end
          if (rise_seen && st_reg.last_dir != DIR_RISE) begin
            // Minimum confirmed; amplitude unknown, so edge may be early
            st_next.speed     = 1'b0;
            st_next.min_valid = 1'b1;
            st_next.min_val   = st_reg.cur_min;
            st_next.cur_max   = sample_in.field;
            st_next.last_dir  = DIR_RISE;
          end else if (fall_seen && st_reg.last_dir != DIR_FALL) begin
            // Driving high shows no edge when this fall comes first; after a rise it is a visible edge
            st_next.speed     = 1'b1;
            st_next.max_valid = 1'b1;
            st_next.max_val   = st_reg.cur_max;
            st_next.cur_min   = sample_in.field;
            st_next.last_dir  = DIR_FALL;
          end
          if (st_next.min_valid && st_next.max_valid) begin
            // Exactly two detected edges, one rise and one fall; a first fall stays unseen
            st_next.mode    = MODE_RUNNING;
            st_next.running = 1'b1;
            // The field still stands on the far side of the new threshold here;
            // pre-arming would let it flip the output at once, so both levels
            // start disarmed and the next edge needs a real hysteresis crossing.
            st_next.pos_seen = 1'b0;
            st_next.neg_seen = 1'b0;
          end
        end
      end

      // ----------------------------------------------------------------------
      MODE_RUNNING: begin
        if (sample_in.valid) begin
          if (sample_in.field < st_reg.cur_min) begin
            st_next.cur_min = sample_in.field;
          end
          if (sample_in.field > st_reg.cur_max) begin
            st_next.cur_max = sample_in.field;
          end
          // Alternation: only the level opposite to the last edge is armed
          if (smp > pos_lvl && st_reg.speed == 1'b0) begin
            st_next.pos_seen = 1'b1;
          end
          if (smp < neg_lvl && st_reg.speed == 1'b1) begin
            st_next.neg_seen = 1'b1;
          end
          // Falling field through threshold: output high
          if (smp < thr && st_next.pos_seen && st_reg.speed == 1'b0) begin
            st_next.speed    = 1'b1;
            st_next.pos_seen = 1'b0;
            st_next.max_val  = st_reg.cur_max;
            st_next.cur_min  = sample_in.field;
          end else if (smp > thr && st_next.neg_seen && st_reg.speed == 1'b1) begin
            // Rising field through threshold: output low
            st_next.speed    = 1'b0;
            st_next.neg_seen = 1'b0;
            st_next.min_val  = st_reg.cur_min;
            st_next.cur_max  = sample_in.field;
          end
        end
      end

      // ----------------------------------------------------------------------
      default: begin
        st_next.mode = MODE_POWER_ON;
      end

    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg.mode      <= MODE_POWER_ON;
      st_reg.speed     <= SPEED_RESET;
      st_reg.running   <= 1'b0;
      st_reg.last_dir  <= DIR_NONE;
      st_reg.min_valid <= 1'b0;
      st_reg.max_valid <= 1'b0;
      st_reg.pos_seen  <= 1'b0;
      st_reg.neg_seen  <= 1'b0;
      st_reg.cur_min   <= '0;
      st_reg.cur_max   <= '0;
      st_reg.min_val   <= '0;
      st_reg.max_val   <= '0;
      st_reg.por_cnt   <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign speed_out   = st_reg.speed;
  assign running_out = st_reg.running;

endmodule : tooth_edge_switching_core

// ---- rtl/tooth_edge_pkg.sv ----
// Package: shared constants, types and field layouts of the tooth edge switching core
package tooth_edge_pkg;

  // ==========================================================================
  // Sample format
  // ==========================================================================
  localparam int unsigned SAMPLE_W = 16;

  typedef logic signed [SAMPLE_W-1:0] field_t;
  typedef logic signed [SAMPLE_W:0]   level_t;

  typedef struct packed {
    logic   valid;
    field_t field;
  } sample_t;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_PS   = 10000;
  localparam int unsigned POWER_ON_TIME_US = 700;
  // Least time, rounded up to whole cycles
  localparam int unsigned POWER_ON_CYCLES =
    (POWER_ON_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned POR_CNT_W = 24;

  // ==========================================================================
  // Thresholds and reset values
  // ==========================================================================
  // Plain default; the trimmed value of a real part is not known here
  localparam int unsigned MIN_SIGNAL_STEP_DEF = 16;
  // Hysteresis offset is amplitude / 8, i.e. 12.5 percent
  localparam int unsigned HYST_SHIFT = 3;
  localparam logic        SPEED_RESET = 1'b1;

  // ==========================================================================
  // Modes and start-up direction
  // ==========================================================================
  typedef enum logic [1:0] {
    MODE_POWER_ON,
    MODE_STARTUP,
    MODE_RUNNING
  } mode_t;

  typedef enum logic [1:0] {
    DIR_NONE,
    DIR_RISE,
    DIR_FALL
  } dir_t;

  typedef struct packed {
    mode_t                mode;
    logic                 speed;
    logic                 running;
    dir_t                 last_dir;
    logic                 min_valid;
    logic                 max_valid;
    logic                 pos_seen;
    logic                 neg_seen;
    field_t               cur_min;
    field_t               cur_max;
    field_t               min_val;
    field_t               max_val;
    logic [POR_CNT_W-1:0] por_cnt;
  } core_state_t;

endpackage : tooth_edge_pkg

// ---- rtl/switch_level_calc.sv ----
// Module: switching threshold and adaptive hysteresis levels from min and max
`timescale 1ns/1ps

module switch_level_calc
  import tooth_edge_pkg::*;
(
  input  wire field_t min_in,
  input  wire field_t max_in,
  output level_t      thr_out,
  output level_t      pos_out,
  output level_t      neg_out
);

  // ==========================================================================
  // Mean and amplitude
  // ==========================================================================
  logic signed [SAMPLE_W+1:0] sum;
  logic signed [SAMPLE_W+1:0] amp;
  logic signed [SAMPLE_W+1:0] offs;
  logic signed [SAMPLE_W+1:0] mean;

  always_comb begin
    sum  = {{2{min_in[SAMPLE_W-1]}}, min_in} + {{2{max_in[SAMPLE_W-1]}}, max_in};
    mean = sum >>> 1;
    amp  = {{2{max_in[SAMPLE_W-1]}}, max_in} - {{2{min_in[SAMPLE_W-1]}}, min_in};
    // A reversed pair would give a negative offset; clamp it to no hysteresis
    offs = amp[SAMPLE_W+1] ? '0 : (amp >>> HYST_SHIFT);
    thr_out = mean[SAMPLE_W:0];
    pos_out = level_t'(mean + offs);
    neg_out = level_t'(mean - offs);
  end

endmodule : switch_level_calc

// ---- test/tooth_edge_switching_core_assertions.sv ----
// Checker: timing relations of the speed output and the mode flag
`timescale 1ns/1ps
module tooth_edge_switching_core_checker
  import tooth_edge_pkg::*;
#(
  parameter int unsigned         POWER_ON_CNT    = POWER_ON_CYCLES,
  parameter logic [SAMPLE_W-1:0] MIN_SIGNAL_STEP = SAMPLE_W'(MIN_SIGNAL_STEP_DEF)
)
(
  input wire logic    clk_sys_in,
  input wire logic    rst_in,
  input wire sample_t sample_in,
  input wire logic    speed_out,
  input wire logic    running_out
);
  // ==========
  // Helpers
  logic [31:0] por_reg;
  logic [1:0]  edges_reg;
  // Visible start-up edges; saturates so a runaway design cannot wrap to zero
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      por_reg   <= '0;
      edges_reg <= '0;
    end else begin
      if (por_reg <= POWER_ON_CNT)
        por_reg <= por_reg + 32'h1;
      if ($changed(speed_out) && !running_out && edges_reg != 2'h3)
        edges_reg <= edges_reg + 2'h1;
    end
  end
  // ==========
  // Properties
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  sequence s_edge;
    $changed(speed_out);
  endsequence
  sequence s_start_edge;
    !running_out ##0 $changed(speed_out);
  endsequence
  a_run_sticky: assert property (running_out |=> running_out)
    else $error("running flag dropped");
  a_por_hold_high: assert property (por_reg < POWER_ON_CNT |-> speed_out)
    else $error("speed low during power-on");
  a_por_no_run: assert property (por_reg <= POWER_ON_CNT |-> !running_out)
    else $error("running during power-on");
  a_edge_has_sample: assert property (s_edge |-> $past(sample_in.valid))
    else $error("speed edge without a sample");
  a_idle_holds: assert property (!sample_in.valid |=> $stable(running_out))
    else $error("mode changed on an empty cycle");
  a_first_edge_low: assert property (s_start_edge |-> !speed_out)
    else $error("start-up edge went high");
  a_run_with_edge: assert property ($rose(running_out) |-> s_edge)
    else $error("running entered without an edge");
  a_startup_edges: assert property (!running_out |-> edges_reg <= 2'h1)
    else $error("too many start-up edges");
endmodule : tooth_edge_switching_core_checker

bind tooth_edge_switching_core tooth_edge_switching_core_checker #(
  .POWER_ON_CNT   (POWER_ON_CNT),
  .MIN_SIGNAL_STEP(MIN_SIGNAL_STEP)
) u_checker (
  .clk_sys_in (clk_sys_in),
  .rst_in     (rst_in),
  .sample_in  (sample_in),
  .speed_out  (speed_out),
  .running_out(running_out)
);

// ---- test/pulse_counter_model.sv ----
// Partner: controller that counts the pulses on the speed output
`timescale 1ns/1ps
module pulse_counter_model (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        speed_in,
  output logic      [15:0] fall_cnt_out,
  output logic      [15:0] rise_cnt_out
);
  logic speed_reg;
  // Sees only settled levels at the clock, as a sampling controller would
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      speed_reg    <= 1'b1;
      fall_cnt_out <= '0;
      rise_cnt_out <= '0;
    end else begin
      speed_reg <= speed_in;
      if (speed_reg && !speed_in)
        fall_cnt_out <= fall_cnt_out + 16'h1;
      if (!speed_reg && speed_in)
        rise_cnt_out <= rise_cnt_out + 16'h1;
    end
  end
endmodule : pulse_counter_model

// ---- test/testbench.sv ----
// Bench: power-on hold, start-up and running mode of the switching core
`timescale 1ns/1ps
module testbench;
  import tooth_edge_pkg::*;
  localparam int unsigned POR_N = 20;
  logic        clk_sys_in  = 1'b0;
  logic        rst_in      = 1'b1;
  sample_t     sample_in   = '0;
  logic        speed_out;
  logic        running_out;
  logic [15:0] fall_cnt;
  logic [15:0] rise_cnt;
  logic [15:0] base;
  int          fail_count  = 0;
  int          tests_run   = 0;
  int          p, n, t, lo, hi;
  always #5 clk_sys_in = ~clk_sys_in;
  tooth_edge_switching_core #(.POWER_ON_CNT(POR_N), .MIN_SIGNAL_STEP(16'h0010)) u_dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .sample_in(sample_in),
    .speed_out(speed_out), .running_out(running_out));
  pulse_counter_model u_ctrl (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .speed_in(speed_out), .fall_cnt_out(fall_cnt), .rise_cnt_out(rise_cnt));
  // ==========
  // Tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out();
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  function automatic int level(input int mn, input int mx, input int sgn);
    return ((mn + mx) >>> 1) + sgn * ((mx - mn) >>> 3);
  endfunction : level
  task automatic put(input int f);
    @(posedge clk_sys_in);
    #1;
    sample_in = {1'b1, 16'(f)};
  endtask : put
  task automatic idle(input int k);
    repeat (k) begin
      @(posedge clk_sys_in);
      #1;
      sample_in.valid = 1'b0;
    end
  endtask : idle
  task automatic ramp(input int a, input int b, input int s);
    int v;
    v = a;
    while ((a <= b) ? v < b : v > b) begin
      put(v);
      v = (a <= b) ? v + s : v - s;
    end
    put(b);
    idle(2);
  endtask : ramp
  task automatic status(input logic s, input logic r);
    check("speed_out", 16'(speed_out), 16'(s));
    check("running_out", 16'(running_out), 16'(r));
  endtask : status
  // Random samples while the analog side settles must leave the output high
  task automatic power_up();
    rst_in = 1'b1;
    repeat (20) @(posedge clk_sys_in);
    #1;
    rst_in = 1'b0;
    for (int i = 0; i < POR_N - 2; i++) begin
      put(int'($urandom % 2000) - 1000);
      check("speed_out", 16'(speed_out), 16'h0001);
    end
    idle(4);
  endtask : power_up
  // ==========
  // Scenarios
  initial begin
    void'($urandom(19));
    power_up();
    status(1'b1, 1'b0);
    ramp(0, 400, 8);
    status(1'b0, 1'b0);
    ramp(400, 0, 8);
    status(1'b1, 1'b1);
    repeat (2) begin
      ramp(0, 400, 8);
      ramp(400, 0, 8);
    end
    check("pulses", fall_cnt, 16'h0003);
    p = level(0, 400, 1);
    t = level(0, 400, 0);
    ramp(0, t, 8);
    status(1'b1, 1'b1);
    put(t + 1);
    idle(2);
    status(1'b0, 1'b1);
    put(p);
    put(t - 10);
    idle(2);
    status(1'b0, 1'b1);
    put(p + 1);
    put(t - 10);
    idle(2);
    status(1'b1, 1'b1);
    n = level(0, p + 1, -1);
    t = level(0, p + 1, 0);
    repeat (6) begin
      put(t + 5);
      put(t - 5);
    end
    put(n);
    put(t + 1);
    idle(2);
    status(1'b1, 1'b1);
    put(n - 1);
    put(t + 1);
    idle(2);
    status(1'b0, 1'b1);
    base = rise_cnt;
    p = t + 1;
    for (int k = 0; k < 8; k++) begin
      hi = 400 + int'($urandom % 101);
      lo = -int'($urandom % 101);
      n = 4 + int'($urandom % 13);
      ramp(p, hi, n);
      ramp(hi, lo, n);
      p = lo;
    end
    check("pulses", rise_cnt - base, 16'h0008);
    power_up();
    ramp(400, 0, 8);
    status(1'b1, 1'b0);
    ramp(0, 400, 8);
    status(1'b0, 1'b1);
    check("pulses", fall_cnt, 16'h0001);
    close_out();
  end
endmodule : testbench
